// ==== verilog/asp_defines.vh ====
// Purpose: Register map, field positions and codes of the audio serial port
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes:   Definitions only
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH
// Register byte offsets
`define ASP_OFS_CTRL   8'h00
`define ASP_OFS_CLK0   8'h04
`define ASP_OFS_CLK1   8'h08
`define ASP_OFS_TXC    8'h0c
`define ASP_OFS_RXC    8'h10
`define ASP_OFS_TXD    8'h14
`define ASP_OFS_RXD    8'h18
`define ASP_OFS_FLAG   8'h1c
`define ASP_OFS_INTEN  8'h20
`define ASP_OFS_SYNC   8'h24
// Control fields
`define ASP_CTRL_EN    0
`define ASP_CTRL_CKEN0 1
`define ASP_CTRL_TXEN  3
`define ASP_CTRL_RXEN  4
`define ASP_CTRL_SWRST 5
`define ASP_CTRL_DBGST 6
// Clock unit fields
`define ASP_CK_MODE    0
`define ASP_CK_NBS     2
`define ASP_CK_SSZ     5
`define ASP_CK_FMT     8
`define ASP_CK_SDIV    10
`define ASP_CK_MDIV    16
// Serializer fields
`define ASP_SR_MONO    0
`define ASP_SR_COMP    1
`define ASP_SR_DSZ     2
`define ASP_SR_SPLIT   5
`define ASP_SR_CLKSEL  6
`define ASP_SR_SLOTEN  8
// Flag fields
`define ASP_FL_TXRDY   0
`define ASP_FL_RXRDY   1
`define ASP_FL_TXUR    2
`define ASP_FL_RXOR    3
`define ASP_FL_RXSLOT  8
// Reset values
`define ASP_CTRL_RST   32'h0000_0000
`define ASP_CLK_RST    32'h0000_0000
`define ASP_SER_RST    32'h0000_0300
`define ASP_INTEN_RST  32'h0000_0000
// Clock unit modes
`define ASP_MD_MASTER  2'h0
`define ASP_MD_SLAVE   2'h1
`define ASP_MD_CTRL    2'h2
`define ASP_MD_SLVMCK  2'h3
// Frame formats
`define ASP_FMT_I2S    2'h0
`define ASP_FMT_TDM    2'h1
`define ASP_FMT_PDM    2'h2
`define ASP_FMT_BURST  2'h3
`endif

// ==== verilog/asp_port.v ====
// Purpose: Audio serial port, two clock units, one transmit and one
//          receive serializer, APB register slave
// Assumes: pclk is also the generic clock source of both clock units
// Notes:   Pins from outside pass two flops before use
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "asp_defines.vh"
module asp_port (
  input  wire        pclk,                       // Bus and generic clock
  input  wire        presetn,                    // Async reset, active low
  input  wire        psel,                       // APB select
  input  wire        penable,                    // APB enable
  input  wire        pwrite,                     // APB direction
  input  wire [7:0]  paddr,                      // APB byte address
  input  wire [31:0] pwdata,                     // APB write data
  output reg  [31:0] prdata,                     // APB read data
  output wire        pready,                     // APB ready
  output wire        pslverr,                    // APB error
  input  wire        wp_en,                      // Write guard active
  input  wire        dbg_halt,                   // Processor halted in debug
  input  wire        dbg_access,                 // Access made by debugger
  input  wire [1:0]  master_clock_line_i,        // Master clock pins in
  output wire [1:0]  master_clock_line_o,        // Master clock pins out
  output wire [1:0]  master_clock_line_oe_n,     // Master clock drive, low
  input  wire [1:0]  serial_bit_clock_line_i,    // Bit clock pins in
  output wire [1:0]  serial_bit_clock_line_o,    // Bit clock pins out
  output wire [1:0]  serial_bit_clock_line_oe_n, // Bit clock drive, low
  input  wire [1:0]  frame_sync_line_i,          // Frame sync pins in
  output wire [1:0]  frame_sync_line_o,          // Frame sync pins out
  output wire [1:0]  frame_sync_line_oe_n,       // Frame sync drive, low
  output reg         serial_data_out,            // Transmit data
  input  wire        serial_data_in,             // Receive data
  output wire [1:0]  dma_tx_req,                 // Transmit DMA requests
  output wire [1:0]  dma_rx_req,                 // Receive DMA requests
  output wire        irq                         // Interrupt request
);
  reg  [31:0] ctrl_reg;
  reg  [31:0] clk0_reg;
  reg  [31:0] clk1_reg;
  reg  [31:0] txc_reg;
  reg  [31:0] rxc_reg;
  reg  [31:0] inten_reg;
  reg         srst_reg;
  reg         tx_ur_reg;
  reg         rx_or_reg;
  reg  [31:0] tx_hold_reg;
  reg         tx_hold_v_reg;
  reg         tx_tag_reg;
  reg         tx_wpar_reg;
  reg  [31:0] tx_sh_reg;
  reg  [31:0] tx_last_reg;
  reg         tx_act_reg;
  reg  [31:0] rx_sh_reg;
  reg  [31:0] rx_hold_reg;
  reg         rx_hold_v_reg;
  reg  [2:0]  rx_tag_reg;
  reg  [15:0] rx_half_reg;
  reg         rx_act_reg;
  reg  [4:0]  pdm_cnt_reg;
  reg  [1:0]  sdi_sy_reg;
  reg  [1:0]  fall_d_reg;
  reg  [31:0] rdata_next;
  // Software reset clears every flop except its own
  wire        rst_n = presetn & ~srst_reg;
  // Sample width from serializer code
  function [5:0] dbits;
    input [2:0] c;
    begin
      case (c)
        3'h1:    dbits = 6'd24;
        3'h2:    dbits = 6'd20;
        3'h3:    dbits = 6'd18;
        3'h4:    dbits = 6'd16;
        3'h5:    dbits = 6'd8;
        default: dbits = 6'd32;
      endcase
    end
  endfunction
  // APB decode and write guard
  wire        acc    = psel & penable;
  wire        setup  = psel & ~penable;
  wire        mapped = (paddr[1:0] == 2'h0) & (paddr <= `ASP_OFS_SYNC);
  wire        unprot = (paddr == `ASP_OFS_TXD) | (paddr == `ASP_OFS_RXD) |
                       (paddr == `ASP_OFS_FLAG) | (paddr == `ASP_OFS_SYNC);
  wire        blocked = wp_en & ~dbg_halt & ~dbg_access & ~unprot;
  wire        wr_ok  = acc & pwrite & mapped & ~blocked;
  wire        rd_rx  = acc & ~pwrite & (paddr == `ASP_OFS_RXD);
  wire        wr_flg = wr_ok & (paddr == `ASP_OFS_FLAG);
  wire        wr_txd = wr_ok & (paddr == `ASP_OFS_TXD);
  assign pready  = 1'b1;
  assign pslverr = acc & (~mapped | (pwrite & blocked));
  wire        halt = dbg_halt & ctrl_reg[`ASP_CTRL_DBGST];
  wire        txen = ctrl_reg[`ASP_CTRL_EN] & ctrl_reg[`ASP_CTRL_TXEN];
  wire        rxen = ctrl_reg[`ASP_CTRL_EN] & ctrl_reg[`ASP_CTRL_RXEN];
  wire        tbrq = tx_hold_v_reg & txen;
  // Per unit outputs
  wire [1:0]  u_rise;
  wire [1:0]  u_fall;
  wire [1:0]  u_act;
  wire [1:0]  u_run;
  wire [5:0]  u_slot;
  wire [9:0]  u_bit;
  wire [9:0]  u_blast;
  wire [3:0]  u_fmt;
  wire [3:0]  u_md;
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1)
    begin : g_unit
      wire [31:0] cfg   = (k == 0) ? clk0_reg : clk1_reg;
      wire [1:0]  md    = cfg[`ASP_CK_MODE +: 2];
      wire [1:0]  fmt   = cfg[`ASP_CK_FMT +: 2];
      wire [4:0]  blast = {cfg[`ASP_CK_SSZ +: 2], 3'b111};
      wire [5:0]  sdiv  = cfg[`ASP_CK_SDIV +: 6];
      wire [3:0]  mdiv  = cfg[`ASP_CK_MDIV +: 4];
      wire        burst = (fmt == `ASP_FMT_BURST);
      wire        single = burst | (fmt == `ASP_FMT_PDM);
      wire [2:0]  nbe   = single ? 3'h0 : cfg[`ASP_CK_NBS +: 3];
      wire        breq  = (k == 0) ? tbrq : 1'b0;
      wire        run   = ctrl_reg[`ASP_CTRL_EN] & ctrl_reg[`ASP_CTRL_CKEN0 + k] & ~halt;
      wire        gen   = (md != `ASP_MD_SLAVE);
      wire        mckdrv = (md == `ASP_MD_MASTER) | (md == `ASP_MD_CTRL);
      reg  [2:0]  sck_sy;
      reg  [2:0]  fs_sy;
      reg  [2:0]  mck_sy;
      reg  [5:0]  scnt;
      reg  [3:0]  mcnt;
      reg         sck_q;
      reg         mck_q;
      reg         fs_q;
      reg         fs_prev;
      reg         fs_seen;
      reg         idle_q;
      reg  [4:0]  bitc;
      reg  [2:0]  slot;
      // Divider source: pclk ticks or edges of an incoming master clock
      wire tick  = (md == `ASP_MD_SLVMCK) ? (mck_sy[1] & ~mck_sy[2]) : 1'b1;
      wire gedge = run & gen & tick & (scnt == sdiv);
      wire rise  = gen ? (gedge & ~sck_q) : (run & sck_sy[1] & ~sck_sy[2]);
      wire fall  = gen ? (gedge & sck_q) : (run & ~sck_sy[1] & sck_sy[2]);
      wire lbit  = (bitc == blast);
      wire [4:0] nb = lbit ? 5'h00 : bitc + 5'h01;
      wire [2:0] ns = lbit ? ((slot == nbe) ? 3'h0 : slot + 3'h1) : slot;
      wire lastf = (nb == blast) & (ns == nbe);
      wire ws    = (nb == blast) ? (ns == nbe) : (ns == 3'h0);
      wire fs_nx = (fmt == `ASP_FMT_I2S) ? ws : (fmt == `ASP_FMT_PDM) ? 1'b0 :
                   (burst ? (lastf & breq) : lastf);
      // Pin synchronisers
      always @(posedge pclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sck_sy <= 3'h0;
          fs_sy  <= 3'h0;
          mck_sy <= 3'h0;
        end
        else
        begin
          sck_sy <= {sck_sy[1:0], serial_bit_clock_line_i[k]};
          fs_sy  <= {fs_sy[1:0], frame_sync_line_i[k]};
          mck_sy <= {mck_sy[1:0], master_clock_line_i[k]};
        end
      end
      // Bit clock, frame sync and slot position
      always @(posedge pclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          scnt    <= 6'h00;
          sck_q   <= 1'b0;
          fs_q    <= 1'b0;
          fs_prev <= 1'b0;
          fs_seen <= 1'b0;
          idle_q  <= 1'b1;
          bitc    <= 5'h00;
          slot    <= 3'h0;
        end
        else if (!run)
        begin
          scnt    <= 6'h00;
          sck_q   <= 1'b0;
          fs_q    <= 1'b0;
          fs_seen <= 1'b0;
          idle_q  <= 1'b1;
        end
        else
        begin
          if (gen & tick)
            scnt <= gedge ? 6'h00 : scnt + 6'h01;
          if (gedge)
            sck_q <= ~sck_q;
          if (rise & ~gen)
          begin
            fs_prev <= fs_sy[1];
            fs_seen <= fs_sy[1] & ~fs_prev;
          end
          if (fall & ~gen)
          begin
            fs_seen <= 1'b0;
            if (fs_seen)
            begin
              bitc   <= 5'h00;
              slot   <= 3'h0;
              idle_q <= 1'b0;
            end
            else if (!idle_q)
            begin
              bitc <= nb;
              slot <= ns;
            end
          end
          else if (fall & idle_q)
          begin
            if (~burst | breq)
            begin
              idle_q <= 1'b0;
              bitc   <= blast;
              slot   <= nbe;
              fs_q   <= (fmt != `ASP_FMT_PDM);
            end
          end
          else if (fall)
          begin
            if (burst & lbit & ~fs_q)
              idle_q <= 1'b1;
            else
            begin
              bitc <= nb;
              slot <= ns;
              fs_q <= fs_nx;
            end
          end
        end
      end
      // Oversampling master clock
      always @(posedge pclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          mcnt  <= 4'h0;
          mck_q <= 1'b0;
        end
        else if (!(run & mckdrv))
        begin
          mcnt  <= 4'h0;
          mck_q <= 1'b0;
        end
        else
        begin
          mcnt <= (mcnt == mdiv) ? 4'h0 : mcnt + 4'h1;
          if (mcnt == mdiv)
            mck_q <= ~mck_q;
        end
      end
      assign u_rise[k]            = rise;
      assign u_fall[k]            = fall;
      assign u_act[k]             = ~idle_q;
      assign u_run[k]             = run;
      assign u_slot[3*k +: 3]     = slot;
      assign u_bit[5*k +: 5]      = bitc;
      assign u_blast[5*k +: 5]    = blast;
      assign u_fmt[2*k +: 2]      = fmt;
      assign u_md[2*k +: 2]       = md;
      assign serial_bit_clock_line_o[k]    = sck_q;
      assign frame_sync_line_o[k]          = fs_q;
      assign master_clock_line_o[k]        = mck_q;
      assign serial_bit_clock_line_oe_n[k] = ~(run & gen);
      assign frame_sync_line_oe_n[k]       = ~(run & gen);
      assign master_clock_line_oe_n[k]     = ~(run & mckdrv);
    end
  endgenerate
  // Transmitter on unit 0
  wire [2:0]  ts    = u_slot[2:0];
  wire        tmono = txc_reg[`ASP_SR_MONO];
  wire        tcomp = txc_reg[`ASP_SR_COMP];
  wire        tpair = tmono | tcomp;
  wire [5:0]  tdsz  = dbits(txc_reg[`ASP_SR_DSZ +: 3]);
  wire        tok   = (u_md[1:0] != `ASP_MD_CTRL) & (u_fmt[1:0] != `ASP_FMT_PDM);
  wire        tss   = fall_d_reg[0] & u_act[0] & (u_bit[4:0] == 5'h00) & tok;
  wire        tgo   = (ts == 3'h0) ? txen : tx_act_reg;
  wire        ten   = tgo & txc_reg[`ASP_SR_SLOTEN + ts];
  wire        tdup  = tpair & ts[0];
  wire        ttake = tx_hold_v_reg & (tpair | (tx_tag_reg == ts[0]));
  wire [31:0] t_lo  = tx_hold_reg << (6'd32 - tdsz);
  wire [31:0] t_hi  = (tx_hold_reg >> tdsz) << (6'd32 - tdsz);
  wire [31:0] t_ld  = ~ten ? 32'h0000_0000 : tdup ? tx_last_reg :
                      ttake ? t_lo : 32'h0000_0000;
  wire        t_use = tss & ten & ~tdup & ttake;
  wire        t_ur  = tss & ten & ~tdup & ~ttake;
  wire [31:0] t_nx  = tss ? t_ld : tx_sh_reg;
  // Transmit holding, shifter and data pin
  always @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_hold_reg     <= 32'h0000_0000;
      tx_hold_v_reg   <= 1'b0;
      tx_tag_reg      <= 1'b0;
      tx_wpar_reg     <= 1'b0;
      tx_sh_reg       <= 32'h0000_0000;
      tx_last_reg     <= 32'h0000_0000;
      tx_act_reg      <= 1'b0;
      serial_data_out <= 1'b0;
    end
    else
    begin
      if (wr_txd)
      begin
        tx_hold_reg   <= pwdata;
        tx_hold_v_reg <= 1'b1;
        tx_tag_reg    <= tx_wpar_reg;
        tx_wpar_reg   <= tpair ? 1'b0 : ~tx_wpar_reg;
      end
      else if (t_use)
        tx_hold_v_reg <= 1'b0;
      else if (t_ur & ~tpair)
        tx_wpar_reg <= ~ts[0];
      if (t_use)
        tx_last_reg <= tmono ? t_lo : t_hi;
      if (!u_run[0])
        tx_act_reg <= 1'b0;
      else if (tss & (ts == 3'h0))
        tx_act_reg <= txen;
      if (!u_run[0])
        serial_data_out <= 1'b0;
      else if (fall_d_reg[0])
      begin
        serial_data_out <= t_nx[31];
        tx_sh_reg       <= {t_nx[30:0], 1'b0};
      end
    end
  end
  // Receiver on the unit it selects
  wire        rsel  = rxc_reg[`ASP_SR_CLKSEL];
  wire [2:0]  rs    = rsel ? u_slot[5:3] : u_slot[2:0];
  wire [4:0]  rb    = rsel ? u_bit[9:5] : u_bit[4:0];
  wire [4:0]  rbl   = rsel ? u_blast[9:5] : u_blast[4:0];
  wire        rpdm  = (rsel ? u_fmt[3:2] : u_fmt[1:0]) == `ASP_FMT_PDM;
  wire        rok   = ((rsel ? u_md[3:2] : u_md[1:0]) != `ASP_MD_CTRL) & u_act[rsel];
  wire        rslv  = (rsel ? u_md[3:2] : u_md[1:0]) == `ASP_MD_SLAVE; // Pin-timed unit
  wire        rmono = rxc_reg[`ASP_SR_MONO];
  wire        rcomp = rxc_reg[`ASP_SR_COMP];
  wire [5:0]  rdsz  = dbits(rxc_reg[`ASP_SR_DSZ +: 3]);
  wire [5:0]  sbits = {1'b0, rbl} + 6'h01;
  wire [5:0]  rshf  = (sbits > rdsz) ? sbits - rdsz : 6'h00;
  wire        r_sh  = rok & (u_rise[rsel] | (rpdm & u_fall[rsel]));
  wire [31:0] rfull = {rx_sh_reg[30:0], sdi_sy_reg[1]};
  wire [31:0] rsmp  = (rfull >> rshf) & ~(32'hffff_ffff << rdsz);
  wire        r_end = rpdm ? (r_sh & (pdm_cnt_reg == 5'h1f)) :
                      (rok & u_rise[rsel] & (rb == rbl));
  wire        r_en  = r_end & rx_act_reg & (rpdm | rxc_reg[`ASP_SR_SLOTEN + rs]);
  wire        r_new = r_en & (rpdm | ~((rmono | rcomp) & ~rs[0] & rcomp) &
                      ~(rmono & rs[0]));
  wire [31:0] rword = rpdm ? rfull : (rcomp ? ((rsmp << rdsz) |
                      {16'h0000, rx_half_reg}) : rsmp);
  // Receive shifter and holding register
  always @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sdi_sy_reg    <= 2'h0;
      rx_sh_reg     <= 32'h0000_0000;
      rx_hold_reg   <= 32'h0000_0000;
      rx_hold_v_reg <= 1'b0;
      rx_tag_reg    <= 3'h0;
      rx_half_reg   <= 16'h0000;
      rx_act_reg    <= 1'b0;
      pdm_cnt_reg   <= 5'h00;
      rx_or_reg     <= 1'b0;
    end
    else
    begin
      sdi_sy_reg <= {sdi_sy_reg[0], serial_data_in};
      if (r_sh)
      begin
        rx_sh_reg   <= rfull;
        pdm_cnt_reg <= pdm_cnt_reg + 5'h01;
      end
      // Slave units start on a sync edge with no partial slot, so arm while idle
      if (!u_run[rsel])
        rx_act_reg <= 1'b0;
      else if (r_end | (rslv & ~u_act[rsel]))
        rx_act_reg <= rxen;
      if (r_en & rcomp & ~rs[0] & ~rpdm)
        rx_half_reg <= rsmp[15:0];
      if (r_new & rx_hold_v_reg & ~rd_rx)
        rx_or_reg <= 1'b1;
      else if (wr_flg & pwdata[`ASP_FL_RXOR])
        rx_or_reg <= 1'b0;
      if (r_new & (~rx_hold_v_reg | rd_rx))
      begin
        rx_hold_reg   <= rword;
        rx_hold_v_reg <= 1'b1;
        rx_tag_reg    <= rs;
      end
      else if (rd_rx)
        rx_hold_v_reg <= 1'b0;
    end
  end
  // Configuration registers, underrun flag, read data register
  always @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg   <= `ASP_CTRL_RST;
      clk0_reg   <= `ASP_CLK_RST;
      clk1_reg   <= `ASP_CLK_RST;
      txc_reg    <= `ASP_SER_RST;
      rxc_reg    <= `ASP_SER_RST;
      inten_reg  <= `ASP_INTEN_RST;
      tx_ur_reg  <= 1'b0;
      fall_d_reg <= 2'h0;
      prdata     <= 32'h0000_0000;
    end
    else
    begin
      fall_d_reg <= u_fall;
      if (setup)
        prdata <= rdata_next;
      if (wr_ok & (paddr == `ASP_OFS_CTRL))
        ctrl_reg <= pwdata & 32'h0000_005f;
      if (wr_ok & (paddr == `ASP_OFS_CLK0))
        clk0_reg <= pwdata & 32'h000f_ffff;
      if (wr_ok & (paddr == `ASP_OFS_CLK1))
        clk1_reg <= pwdata & 32'h000f_ffff;
      if (wr_ok & (paddr == `ASP_OFS_TXC))
        txc_reg <= pwdata & 32'h0000_ff3f;
      if (wr_ok & (paddr == `ASP_OFS_RXC))
        rxc_reg <= pwdata & 32'h0000_ff7f;
      if (wr_ok & (paddr == `ASP_OFS_INTEN))
        inten_reg <= pwdata & 32'h0000_000f;
      if (t_ur)
        tx_ur_reg <= 1'b1;
      else if (wr_flg & pwdata[`ASP_FL_TXUR])
        tx_ur_reg <= 1'b0;
    end
  end
  // Software reset pulse, held on bus reset only
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      srst_reg <= 1'b0;
    else
      srst_reg <= wr_ok & (paddr == `ASP_OFS_CTRL) & pwdata[`ASP_CTRL_SWRST];
  end
  // Status word and read mux
  wire [31:0] flags = {21'h000000, rx_tag_reg, 4'h0, rx_or_reg, tx_ur_reg,
                       rx_hold_v_reg, ~tx_hold_v_reg};
  always @*
  begin
    case (paddr)
      `ASP_OFS_CTRL:  rdata_next = ctrl_reg;
      `ASP_OFS_CLK0:  rdata_next = clk0_reg;
      `ASP_OFS_CLK1:  rdata_next = clk1_reg;
      `ASP_OFS_TXC:   rdata_next = txc_reg;
      `ASP_OFS_RXC:   rdata_next = rxc_reg;
      `ASP_OFS_RXD:   rdata_next = rx_hold_reg;
      `ASP_OFS_FLAG:  rdata_next = flags;
      `ASP_OFS_INTEN: rdata_next = inten_reg;
      `ASP_OFS_SYNC:  rdata_next = {31'h0000_0000, srst_reg};
      default:        rdata_next = 32'h0000_0000;
    endcase
  end
  // DMA requests, single or per channel
  wire tx_need = txen & ~tx_hold_v_reg;
  wire rx_have = rxen & rx_hold_v_reg;
  assign dma_tx_req[0] = tx_need & (~txc_reg[`ASP_SR_SPLIT] | ~tx_wpar_reg);
  assign dma_tx_req[1] = tx_need & txc_reg[`ASP_SR_SPLIT] & tx_wpar_reg;
  assign dma_rx_req[0] = rx_have & (~rxc_reg[`ASP_SR_SPLIT] | ~rx_tag_reg[0]);
  assign dma_rx_req[1] = rx_have & rxc_reg[`ASP_SR_SPLIT] & rx_tag_reg[0];
  // Interrupt from enabled flags
  assign irq = |(flags[3:0] & inten_reg[3:0]);
endmodule // asp_port

// ==== sim/asp_port_checker.sv ====
// Purpose: Port checks of the audio serial port
// Assumes: Bound into asp_port, one clock domain
// Notes:   Offsets from asp_defines.vh
`timescale 1ns/1ps
`include "asp_defines.vh"
module asp_port_checker (
  input wire       pclk,                       // Clock
  input wire       presetn,                    // Reset, low
  input wire       psel,                       // Select
  input wire       penable,                    // Enable
  input wire       pwrite,                     // Direction
  input wire [7:0] paddr,                      // Address
  input wire [31:0] prdata,                    // Read data
  input wire       pready,                     // Ready
  input wire       pslverr,                    // Error
  input wire       wp_en,                      // Guard on
  input wire       dbg_halt,                   // Debug halt
  input wire       dbg_access,                 // Debugger access
  input wire [1:0] serial_bit_clock_line_o,    // Bit clock out
  input wire [1:0] serial_bit_clock_line_oe_n, // Bit clock drive
  input wire [1:0] frame_sync_line_oe_n,       // Frame sync drive
  input wire       serial_data_out             // Transmit data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase and guard state
  sequence s_acc;
    psel && penable;
  endsequence
  wire guarded = wp_en && !dbg_halt && !dbg_access;
  property p_ready; s_acc |-> pready; endproperty
  property p_err_phase; pslverr |-> s_acc; endproperty
  property p_guard;
    s_acc ##0 (pwrite && guarded && paddr == `ASP_OFS_CLK1) |-> pslverr;
  endproperty
  property p_data_open; s_acc ##0 (pwrite && paddr == `ASP_OFS_TXD) |-> !pslverr; endproperty
  property p_dbg_lift;
    s_acc ##0 (pwrite && (dbg_halt || dbg_access) && paddr == `ASP_OFS_CLK0) |-> !pslverr;
  endproperty
  property p_unmapped;
    s_acc ##0 (!pwrite && paddr > 8'h24) |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  property p_drive_pair; serial_bit_clock_line_oe_n[0] == frame_sync_line_oe_n[0]; endproperty
  property p_launch;
    $changed(serial_data_out) && !serial_bit_clock_line_oe_n[0] |->
      $past(serial_bit_clock_line_o[0], 2) && !$past(serial_bit_clock_line_o[0]);
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  a_guard: assert property (p_guard) else $error("guarded write taken");
  a_data_open: assert property (p_data_open) else $error("data write refused");
  a_dbg_lift: assert property (p_dbg_lift) else $error("debug write refused");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
  a_drive_pair: assert property (p_drive_pair) else $error("clock drive mismatch");
  a_launch: assert property (p_launch) else $error("data not after clock fall");
endmodule // asp_port_checker
bind asp_port asp_port_checker i_asp_port_checker (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .wp_en, .dbg_halt, .dbg_access, .serial_bit_clock_line_o,
  .serial_bit_clock_line_oe_n, .frame_sync_line_oe_n, .serial_data_out);

// ==== sim/asp_codec_model.sv ====
// Purpose: Codec sending slave-mode TDM frames
// Assumes: Bit clock of 160 ns, only inside frames
// Notes:   Released data line shows the inverse value
`timescale 1ns/1ps
module asp_codec_model (
  output logic c_sck,          // Bit clock
  output logic c_fs,           // Frame sync
  output logic serial_data_in  // Data to port
);
  // Idle levels
  initial
  begin
    c_sck = 1'b0;
    c_fs = 1'b0;
    serial_data_in = 1'b0;
  end
  // One frame, sync one bit early, MSB first
  task automatic send(input logic [15:0] word);
    c_fs = 1'b1;
    #80 c_sck = 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      #80 c_sck = 1'b0;
      c_fs = 1'b0;
      serial_data_in = word[i];
      #80 c_sck = 1'b1;
    end
    #80 c_sck = 1'b0;
    serial_data_in = ~serial_data_in;
  endtask
endmodule // asp_codec_model

// ==== sim/test_asp_port.sv ====
// Purpose: Bench of the audio serial port
// Assumes: 200 MHz pclk, zero-wait APB
// Notes:   Register table loop, then hand tests
`timescale 1ns/1ps
`include "asp_defines.vh"
module test_asp_port;
  logic pclk, presetn, psel, penable, pwrite, wp_en, dbg_halt, dbg_access, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] master_clock_line_o, master_clock_line_oe_n, serial_bit_clock_line_o;
  logic [1:0] serial_bit_clock_line_oe_n, frame_sync_line_o, frame_sync_line_oe_n;
  logic [1:0] dma_tx_req, dma_rx_req;
  logic serial_data_out, serial_data_in, c_sck, c_fs, er;
  logic [15:0] bits;
  int errors, tests_run;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, r; logic e;} asp_row;
  asp_row rows [8] = '{'{0, 8'h00, 0, 0, 0}, '{0, 8'h0c, 0, 32'h0000_0300, 0},
    '{0, 8'h10, 0, 32'h0000_0300, 0}, '{0, 8'h20, 0, 0, 0}, '{1, 8'h20, 32'h0000_000f, 0, 0},
    '{0, 8'h20, 0, 32'h0000_000f, 0}, '{0, 8'h28, 0, 0, 1}, '{0, 8'h02, 0, 0, 1}};
  // Design and far side, clock pins fed from whoever drives
  asp_port i_asp_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .wp_en, .dbg_halt, .dbg_access, .master_clock_line_i(master_clock_line_o),
    .master_clock_line_o, .master_clock_line_oe_n, .serial_bit_clock_line_i({serial_bit_clock_line_oe_n[1]
    ? c_sck : serial_bit_clock_line_o[1], serial_bit_clock_line_o[0]}), .serial_bit_clock_line_o,
    .serial_bit_clock_line_oe_n, .frame_sync_line_i({frame_sync_line_oe_n[1] ? c_fs
    : frame_sync_line_o[1], frame_sync_line_o[0]}), .frame_sync_line_o, .frame_sync_line_oe_n,
    .serial_data_out, .serial_data_in, .dma_tx_req, .dma_rx_req, .irq);
  asp_codec_model i_asp_codec_model (.c_sck, .c_fs, .serial_data_in);
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Compare and count
  task automatic chk(input string n, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, exp, got);
    end
  endtask
  // Verdict
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    conclude;
  end
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, wp_en, dbg_halt, dbg_access} = 0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("idle drive", 32'h0000_003f, {26'h0, master_clock_line_oe_n,
      serial_bit_clock_line_oe_n, frame_sync_line_oe_n});
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("prdata", rows[i].r, rd);
      chk("pslverr", 32'(rows[i].e), 32'(er));
    end
    $display("register table done");
    wp_en <= 1'b1;
    apb(1, `ASP_OFS_CLK1, 32'h0000_0105);
    chk("guard err", 1, 32'(er));
    apb(0, `ASP_OFS_CLK1, 0);
    chk("guarded reg", 0, rd);
    dbg_halt <= 1'b1;
    apb(1, `ASP_OFS_CLK1, 32'h0000_0105);
    chk("debug lift", 0, 32'(er));
    dbg_halt <= 1'b0;
    apb(1, `ASP_OFS_TXD, 32'h0000_00a5);
    chk("data open", 0, 32'(er));
    wp_en <= 1'b0;
    $display("write guard done");
    apb(1, `ASP_OFS_CLK0, 32'h0000_0d04);
    apb(1, `ASP_OFS_TXC, 32'h0000_0315);
    apb(1, `ASP_OFS_RXC, 32'h0000_0354);
    apb(1, `ASP_OFS_CTRL, 32'h0000_001f);
    chk("unit drive", 32'h0000_0002, 32'(serial_bit_clock_line_oe_n));
    chk("mck drive", 32'h0000_0002, 32'(master_clock_line_oe_n));
    fork
      i_asp_codec_model.send(16'h5a3c);
      begin
        @(posedge serial_bit_clock_line_o[0] iff frame_sync_line_o[0]);
        for (int k = 15; k >= 0; k--)
        begin
          @(posedge serial_bit_clock_line_o[0]);
          bits[k] = serial_data_out;
        end
      end
    join
    chk("tx frame", 32'h0000_a5a5, 32'(bits));
    repeat (8) @(posedge pclk);
    apb(0, `ASP_OFS_FLAG, 0);
    chk("rx flags", 32'h0000_000a, rd & 32'h0000_070a);
    chk("dma req", 32'h0000_0005, 32'({dma_tx_req, dma_rx_req}));
    chk("irq", 1, 32'(irq));
    apb(0, `ASP_OFS_RXD, 0);
    chk("rx word", 32'h0000_005a, rd);
    $display("frame test done");
    apb(1, `ASP_OFS_CTRL, 32'h0000_0020);
    apb(0, `ASP_OFS_CLK0, 0);
    chk("soft reset", 0, rd);
    $display("soft reset done");
    conclude;
  end
endmodule // test_asp_port
